// ===== rtl/eeprom_engine_pkg.sv
// shared constants for the serial eeprom instruction engine
package eeprom_engine_pkg;
  // ****************************************
  // word and address geometry
  // ****************************************
  localparam int WORD_W = 16;
  localparam int ADDR_W = 8;
  localparam int ADDR_NARROW = 6;
  localparam int ADDR_WIDE = 8;
  localparam int MEM_WORDS = 256;
  localparam int PAGE_WORDS = 4;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_W = ADDR_W + WORD_W;
  localparam int CNT_W = 8;
  // ****************************************
  // instruction encodings
  // ****************************************
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_PAGE = 2'h3;
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] EXT_UNLOCK = 2'h3;
  localparam logic [1:0] EXT_LOCK = 2'h0;
  localparam logic [1:0] EXT_FILL = 2'h1;
  localparam logic [CNT_W-1:0] HDR_BITS = 8'h03;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int PROG_TIME_NS = 1000000;
  localparam int PROG_CYCLES = PROG_TIME_NS * CLK_MHZ / 1000;
  localparam int STATUS_DELAY_NS = 250;
  localparam int STATUS_CYCLES = (STATUS_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  // ****************************************
  // engine states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD = 3'b001,
    ST_DATA = 3'b010,
    ST_READ = 3'b011,
    ST_TAIL = 3'b100,
    ST_PROG = 3'b101
  } state_type;
  typedef enum logic [1:0] {
    K_WRITE = 2'b00,
    K_PAGE = 2'b01,
    K_FILL = 2'b10,
    K_NONE = 2'b11
  } kind_type;
endpackage

// ===== rtl/serial_eeprom_rw_engine.sv
// serial eeprom instruction engine with write-word fifo
`timescale 1ns/1ps

// ****************************************
// write-word fifo
// ****************************************
module word_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0] wr_ptr;
  logic [PW:0] rd_ptr;
  logic do_push;
  logic do_pop;

  assign in_ready = (wr_ptr - rd_ptr) != (PW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = store[rd_ptr[PW-1:0]];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  always_ff @(posedge sys_clk)
  begin
    if (do_push)
    begin
      store[wr_ptr[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else if (flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// ****************************************
// instruction engine
// ****************************************
// Contract
// - read sends zero, then 16 bits MSB first
// - read output bit changes only on clock rise
// - held select streams next word, no zero
// - write latch disabled at reset
// - latch stays on until lock or reset
// - reads work whatever the latch state
// - input bits sampled on clock rise
// - select falls right after last bit, else none
// - after status delay, output shows busy/ready
// - input ignored while programming
// - ready high until start bit or select low
// - programming timed internally, clock irrelevant
// - page write takes one to four words
// - page address wraps in two low bits
// - page rejected if any word protected
// - fill runs only with boundary cleared
// - fill writes one word everywhere
// - start is first one sampled on rise
// - address six or eight bits by density
// - wrong clock count aborts programming
module serial_eeprom_rw_engine #(
  parameter int PROG_CYCLES = eeprom_engine_pkg::PROG_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // serial pins
  input wire logic select_pin,
  input wire logic sclk_pin,
  input wire logic din_pin,
  output logic dout,
  output logic dout_oe_n,
  // configuration pins
  input wire logic write_permit,
  input wire logic wide_addr,
  input wire logic [7:0] boundary_addr,
  input wire logic boundary_cleared,
  // status
  output logic write_enabled,
  output logic busy
);
  // ****************************************
  // pin synchronisers and edges
  // ****************************************
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic clk_prev;
  logic sel_prev;
  logic sel_s;
  logic clk_s;
  logic din_s;
  logic wp_s;
  logic wide_s;
  logic c_rise;
  logic s_fall;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
      clk_prev <= 1'b0;
      sel_prev <= 1'b0;
    end
    else
    begin
      pin_meta <= {wide_addr, write_permit, din_pin, sclk_pin, select_pin};
      pin_sync <= pin_meta;
      clk_prev <= pin_sync[1];
      sel_prev <= pin_sync[0];
    end
  end

  assign sel_s = pin_sync[0];
  assign clk_s = pin_sync[1];
  assign din_s = pin_sync[2];
  assign wp_s = pin_sync[3];
  assign wide_s = pin_sync[4];
  assign c_rise = clk_s && !clk_prev;
  assign s_fall = !sel_s && sel_prev;

  // ****************************************
  // decode helpers
  // ****************************************
  eeprom_engine_pkg::state_type st;
  eeprom_engine_pkg::kind_type kind;
  logic [15:0] mem [eeprom_engine_pkg::MEM_WORDS];
  logic [7:0] cnt;
  logic [1:0] op;
  logic [7:0] addr;
  logic [7:0] base_addr;
  logic [15:0] sh;
  logic [3:0] bitpos;
  logic [2:0] nwords;
  logic overflow;
  logic [7:0] abits;
  logic [7:0] amask;
  logic [7:0] hdr_len;
  logic [7:0] next_addr;
  logic [1:0] ext;
  logic [1:0] ext_held;
  logic hdr_done;
  logic word_done;
  logic count_ok;
  logic prot_ok;
  logic go_prog;
  logic commit_unlock;
  logic commit_lock;
  logic prog_done;
  logic stat_ok;
  logic ready_show;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [23:0] fifo_out;
  logic fifo_flush;
  logic [15:0] rd_word;

  assign abits = wide_s ? 8'(eeprom_engine_pkg::ADDR_WIDE)
                        : 8'(eeprom_engine_pkg::ADDR_NARROW);
  assign amask = wide_s ? 8'hFF : 8'h3F;
  assign hdr_len = eeprom_engine_pkg::HDR_BITS + abits;
  assign next_addr = {addr[6:0], din_s} & amask;
  assign ext = wide_s ? next_addr[7:6] : next_addr[5:4];
  // at select fall the address is complete; next_addr would shift it once more
  assign ext_held = wide_s ? addr[7:6] : addr[5:4];
  assign hdr_done = st == eeprom_engine_pkg::ST_CMD && c_rise
                    && cnt == hdr_len - 8'h01;
  assign word_done = st == eeprom_engine_pkg::ST_DATA && c_rise && bitpos == 4'hF;

  // expected pulse count from start bit to select fall
  always_comb
  begin
    count_ok = 1'b0;
    case (kind)
      eeprom_engine_pkg::K_PAGE:
        count_ok = bitpos == 4'h0 && nwords != 3'h0
                   && nwords <= 3'(eeprom_engine_pkg::PAGE_WORDS)
                   && cnt == hdr_len + {1'b0, nwords, 4'h0};
      eeprom_engine_pkg::K_NONE:
        count_ok = cnt == hdr_len;
      default:
        count_ok = cnt == hdr_len + 8'h10;
    endcase
  end

  always_comb
  begin
    prot_ok = 1'b0;
    case (kind)
      eeprom_engine_pkg::K_WRITE:
        prot_ok = boundary_cleared || base_addr < boundary_addr;
      eeprom_engine_pkg::K_PAGE:
        prot_ok = boundary_cleared || {base_addr[7:2], 2'h3} < boundary_addr;
      eeprom_engine_pkg::K_FILL:
        prot_ok = boundary_cleared;
      default:
        prot_ok = 1'b0;
    endcase
  end

  // a misplaced select fall fails the count and nothing is programmed
  assign go_prog = s_fall && st == eeprom_engine_pkg::ST_DATA && count_ok && prot_ok
                   && write_enabled && wp_s && !overflow;
  assign commit_unlock = s_fall && st == eeprom_engine_pkg::ST_TAIL && count_ok
                         && op == eeprom_engine_pkg::OP_EXT && wp_s
                         && ext_held == eeprom_engine_pkg::EXT_UNLOCK;
  assign commit_lock = s_fall && st == eeprom_engine_pkg::ST_TAIL && count_ok
                       && op == eeprom_engine_pkg::OP_EXT
                       && ext_held == eeprom_engine_pkg::EXT_LOCK;
  assign fifo_flush = s_fall && st != eeprom_engine_pkg::ST_PROG && !go_prog;

  // ****************************************
  // instruction decoder
  // ****************************************
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= eeprom_engine_pkg::ST_IDLE;
      kind <= eeprom_engine_pkg::K_NONE;
      cnt <= '0;
      op <= '0;
      addr <= '0;
      base_addr <= '0;
      sh <= '0;
      bitpos <= '0;
      nwords <= '0;
      overflow <= 1'b0;
    end
    else if (st == eeprom_engine_pkg::ST_PROG)
    begin
      if (prog_done)
        st <= eeprom_engine_pkg::ST_IDLE;
    end
    else if (s_fall)
    begin
      st <= go_prog ? eeprom_engine_pkg::ST_PROG : eeprom_engine_pkg::ST_IDLE;
    end
    else if (c_rise && sel_s)
    begin
      case (st)
        eeprom_engine_pkg::ST_IDLE:
          if (din_s)
          begin
            st <= eeprom_engine_pkg::ST_CMD;
            cnt <= 8'h01;
            addr <= '0;
            nwords <= '0;
            bitpos <= '0;
            overflow <= 1'b0;
          end
        eeprom_engine_pkg::ST_CMD:
        begin
          cnt <= cnt + 8'h01;
          if (cnt < eeprom_engine_pkg::HDR_BITS)
            op <= {op[0], din_s};
          else
            addr <= next_addr;
          if (hdr_done)
          begin
            base_addr <= next_addr;
            kind <= eeprom_engine_pkg::K_NONE;
            st <= eeprom_engine_pkg::ST_TAIL;
            case (op)
              eeprom_engine_pkg::OP_READ:
                st <= eeprom_engine_pkg::ST_READ;
              eeprom_engine_pkg::OP_WRITE:
              begin
                kind <= eeprom_engine_pkg::K_WRITE;
                st <= eeprom_engine_pkg::ST_DATA;
              end
              eeprom_engine_pkg::OP_PAGE:
              begin
                kind <= eeprom_engine_pkg::K_PAGE;
                st <= eeprom_engine_pkg::ST_DATA;
              end
              default:
                if (ext == eeprom_engine_pkg::EXT_FILL)
                begin
                  kind <= eeprom_engine_pkg::K_FILL;
                  st <= eeprom_engine_pkg::ST_DATA;
                end
            endcase
          end
        end
        eeprom_engine_pkg::ST_DATA:
        begin
          cnt <= cnt + 8'h01;
          sh <= {sh[14:0], din_s};
          bitpos <= bitpos + 4'h1;
          if (word_done)
          begin
            nwords <= nwords == 3'h7 ? nwords : nwords + 3'h1;
            addr <= {addr[7:2], addr[1:0] + 2'h1} & amask;
            if (!fifo_in_ready)
              overflow <= 1'b1;
          end
        end
        eeprom_engine_pkg::ST_READ:
          addr <= addr;
        default:
          cnt <= cnt == 8'hFF ? cnt : cnt + 8'h01;
      endcase
    end
  end

  // ****************************************
  // write-enable latch
  // ****************************************
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      write_enabled <= 1'b0;
    else if (commit_unlock)
      write_enabled <= 1'b1;
    else if (commit_lock)
      write_enabled <= 1'b0;
  end

  word_fifo #(
    .WIDTH(eeprom_engine_pkg::FIFO_W),
    .DEPTH(eeprom_engine_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .flush(fifo_flush),
    .in_valid(word_done),
    .in_ready(fifo_in_ready),
    .in_data({addr, sh[14:0], din_s}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  // ****************************************
  // self-timed programming
  // ****************************************
  logic [31:0] prog_timer;
  logic [7:0] fill_idx;
  logic filling;
  logic [15:0] fill_data;
  logic [7:0] sd_cnt;

  // drain only while programming, so the fifo really fills during shifting
  assign fifo_pop = st == eeprom_engine_pkg::ST_PROG && !filling;
  assign prog_done = st == eeprom_engine_pkg::ST_PROG && prog_timer == 32'h0
                     && !filling && !fifo_out_valid;
  assign stat_ok = sd_cnt == 8'(eeprom_engine_pkg::STATUS_CYCLES);
  assign busy = st == eeprom_engine_pkg::ST_PROG;

  always_ff @(posedge sys_clk)
  begin
    if (filling)
      mem[fill_idx] <= fill_data;
    else if (fifo_pop && fifo_out_valid && kind != eeprom_engine_pkg::K_FILL)
      mem[fifo_out[23:16]] <= fifo_out[15:0];
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prog_timer <= '0;
      fill_idx <= '0;
      filling <= 1'b0;
      fill_data <= eeprom_engine_pkg::RESET_WORD;
      sd_cnt <= '0;
    end
    else if (go_prog)
    begin
      prog_timer <= 32'(PROG_CYCLES);
      sd_cnt <= '0;
      fill_idx <= '0;
    end
    else if (busy)
    begin
      if (prog_timer != 32'h0)
        prog_timer <= prog_timer - 32'h1;
      if (!stat_ok)
        sd_cnt <= sd_cnt + 8'h01;
      if (fifo_pop && fifo_out_valid && kind == eeprom_engine_pkg::K_FILL)
      begin
        fill_data <= fifo_out[15:0];
        filling <= 1'b1;
      end
      else if (filling)
      begin
        fill_idx <= fill_idx + 8'h01;
        if (fill_idx == (wide_s ? 8'hFF : 8'h3F))
          filling <= 1'b0;
      end
    end
  end

  // ****************************************
  // serial output
  // ****************************************
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dout <= 1'b1;
      rd_word <= '0;
      ready_show <= 1'b0;
    end
    else if (prog_done)
    begin
      dout <= 1'b1;
      ready_show <= 1'b1;
    end
    else if (busy)
    begin
      if (sel_s && stat_ok)
        dout <= 1'b0;
    end
    else if (ready_show)
    begin
      if (!sel_s || (c_rise && din_s))
        ready_show <= 1'b0;
    end
    else if (hdr_done && op == eeprom_engine_pkg::OP_READ)
    begin
      dout <= 1'b0;
      rd_word <= mem[next_addr];
    end
    else if (st == eeprom_engine_pkg::ST_READ && c_rise && sel_s)
    begin
      dout <= rd_word[15];
      if (rd_pos == 4'hF)
        rd_word <= mem[(rd_addr + 8'h01) & amask];
      else
        rd_word <= {rd_word[14:0], 1'b0};
    end
  end

  // stream counter: reload the following word as its predecessor's last bit leaves
  logic [3:0] rd_pos;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      rd_pos <= '0;
    else if (hdr_done)
      rd_pos <= '0;
    else if (st == eeprom_engine_pkg::ST_READ && c_rise && sel_s)
      rd_pos <= rd_pos + 4'h1;
  end

  logic [7:0] rd_addr;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      rd_addr <= '0;
    else if (hdr_done)
      rd_addr <= next_addr;
    else if (st == eeprom_engine_pkg::ST_READ && c_rise && sel_s && rd_pos == 4'hF)
      rd_addr <= (rd_addr + 8'h01) & amask;
  end

  assign dout_oe_n = !(sel_s && (st == eeprom_engine_pkg::ST_READ
                     || (busy && stat_ok) || ready_show));

  // ****************************************
  // checks
  // ****************************************
  sequence seq_status_watch;
    busy && sel_s && stat_ok && !prog_done;
  endsequence

  sequence seq_read_start;
    hdr_done && op == eeprom_engine_pkg::OP_READ;
  endsequence

  a_latch_rise_cause: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(write_enabled) |-> $past(commit_unlock))
    else $error("write latch set without unlock");

  a_latch_fall_cause: assert property (@(posedge sys_clk) disable iff (!rstn)
    $fell(write_enabled) |-> $past(commit_lock))
    else $error("write latch cleared without lock");

  a_read_dummy_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    seq_read_start |=> !dout && st == eeprom_engine_pkg::ST_READ)
    else $error("read did not open with a zero bit");

  a_read_edge_only: assert property (@(posedge sys_clk) disable iff (!rstn)
    (st == eeprom_engine_pkg::ST_READ && $past(st) == eeprom_engine_pkg::ST_READ
     && $changed(dout)) |-> $past(c_rise))
    else $error("read output changed without clock rise");

  a_stream_next: assert property (@(posedge sys_clk) disable iff (!rstn)
    (st == eeprom_engine_pkg::ST_READ && c_rise && sel_s && rd_pos == 4'hF)
    |=> rd_pos == 4'h0 && rd_addr == (($past(rd_addr) + 8'h01) & amask))
    else $error("stream did not advance to next word");

  a_busy_shows_low: assert property (@(posedge sys_clk) disable iff (!rstn)
    seq_status_watch |=> !dout && (dout_oe_n != sel_s))
    else $error("busy status not shown low");

  a_ready_high: assert property (@(posedge sys_clk) disable iff (!rstn)
    ready_show |-> dout)
    else $error("ready status not high");

  a_prog_deaf: assert property (@(posedge sys_clk) disable iff (!rstn)
    (busy && !prog_done) |=> busy && $stable(cnt) && $stable(addr))
    else $error("input activity left programming state");

  a_prog_timed: assert property (@(posedge sys_clk) disable iff (!rstn)
    go_prog |=> busy && prog_timer == 32'(PROG_CYCLES))
    else $error("programming timer not loaded");

  a_abort_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
    (s_fall && st == eeprom_engine_pkg::ST_DATA && !count_ok)
    |=> st == eeprom_engine_pkg::ST_IDLE && !fifo_out_valid)
    else $error("bad clock count did not abort");

  a_page_wrap: assert property (@(posedge sys_clk) disable iff (!rstn)
    (word_done && kind == eeprom_engine_pkg::K_PAGE) |=> addr[7:2] == base_addr[7:2])
    else $error("page address left its page");

  a_fill_guard: assert property (@(posedge sys_clk) disable iff (!rstn)
    (go_prog && kind == eeprom_engine_pkg::K_FILL) |-> boundary_cleared)
    else $error("fill started with boundary set");
endmodule

// ===== verif/bus_host.sv
// serial bus master model for the eeprom engine
`timescale 1ns/1ps
module bus_host (
  // clock
  input wire logic sys_clk,
  // serial pins
  output logic select_pin,
  output logic sclk_pin,
  output logic din_pin,
  input wire logic dout,
  input wire logic dout_oe_n
);
  logic q_held;
  logic q_line;
  // a released output reads as the inverse of its last value, so a stale bit never passes
  always @(posedge sys_clk)
  begin
    if (!dout_oe_n)
    begin
      q_held <= dout;
    end
  end
  assign q_line = dout_oe_n ? ~q_held : dout;
  initial
  begin
    select_pin = 1'b0;
    sclk_pin = 1'b0;
    din_pin = 1'b0;
  end
  // ********
  // pin drivers, moved just after a clock edge
  // ********
  task automatic ticks(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic frame_start();
    sclk_pin = 1'b0;
    select_pin = 1'b1;
    ticks(4);
  endtask
  task automatic frame_end();
    select_pin = 1'b0;
    ticks(4);
  endtask
  // data is set in the low phase; the line is read just before the rise
  task automatic clk_bit(input logic b, output logic q);
    din_pin = b;
    ticks(4);
    q = q_line;
    sclk_pin = 1'b1;
    ticks(4);
    sclk_pin = 1'b0;
  endtask
  task automatic send_bits(input logic [31:0] v, input int n);
    logic q;
    for (int i = n - 1; i >= 0; i--)
    begin
      clk_bit(v[i], q);
    end
  endtask
  task automatic read_seq(input logic [7:0] a, input logic wide, input int n,
                          output logic [15:0] w [4], output logic dummy);
    logic q;
    frame_start();
    send_bits(32'({1'b1, eeprom_engine_pkg::OP_READ}), 3);
    send_bits(32'(a), wide ? 8 : 6);
    clk_bit(1'b0, dummy);
    for (int k = 0; k < n; k++)
    begin
      for (int i = 15; i >= 0; i--)
      begin
        clk_bit(1'b0, q);
        w[k][i] = q;
      end
    end
    frame_end();
  endtask
endmodule

// ===== verif/serial_eeprom_rw_engine_bench.sv
// self-checking bench for the serial eeprom instruction engine
`timescale 1ns/1ps
module serial_eeprom_rw_engine_bench;
  // short programming time keeps the run brief; fill still fits
  localparam int PROG = 400;
  logic sys_clk;
  logic rstn;
  logic select_pin;
  logic sclk_pin;
  logic din_pin;
  logic dout;
  logic dout_oe_n;
  logic write_permit;
  logic wide_addr;
  logic [7:0] boundary_addr;
  logic boundary_cleared;
  logic write_enabled;
  logic busy;
  int num_errors;
  int compares;
  logic [31:0] seed = 32'h98BAC2F6;
  logic [31:0] r;
  logic [31:0] w;
  logic [15:0] mem [256];
  logic [15:0] rw [4];
  logic dq;
  logic [7:0] a;
  logic [7:0] a0;
  logic [15:0] d;

  serial_eeprom_rw_engine #(.PROG_CYCLES(PROG)) u_serial_eeprom_rw_engine (
    .sys_clk(sys_clk), .rstn(rstn), .select_pin(select_pin), .sclk_pin(sclk_pin),
    .din_pin(din_pin), .dout(dout), .dout_oe_n(dout_oe_n), .write_permit(write_permit),
    .wide_addr(wide_addr), .boundary_addr(boundary_addr),
    .boundary_cleared(boundary_cleared), .write_enabled(write_enabled), .busy(busy));
  bus_host u_bus_host (.sys_clk(sys_clk), .select_pin(select_pin), .sclk_pin(sclk_pin),
    .din_pin(din_pin), .dout(dout), .dout_oe_n(dout_oe_n));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ********
  // expectations and checks
  // ********
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] wr_bits(input logic [1:0] op, input logic [7:0] ad,
                                          input logic [15:0] dw);
    return {5'h00, 1'b1, op, ad, dw};
  endfunction
  function automatic logic [7:0] page_addr(input logic [7:0] s, input int k);
    return {s[7:2], 2'(s[1:0] + k)};
  endfunction
  task automatic check_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_test(input string s);
    $display("test %0s done at %0t", s, $time);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic instr(input logic [31:0] bits, input int n);
    u_bus_host.frame_start();
    u_bus_host.send_bits(bits, n);
    u_bus_host.frame_end();
  endtask
  // status poll with 20 random clock pulses sent while busy
  task automatic prog_status();
    int n;
    check_flag(busy, 1'b1);
    u_bus_host.ticks(eeprom_engine_pkg::STATUS_CYCLES + 5);
    u_bus_host.frame_start();
    check_flag(u_bus_host.q_line, 1'b0);
    u_bus_host.send_bits(rnd(), 20);
    check_flag(busy, 1'b1);
    n = 0;
    while (busy === 1'b1 && n < PROG)
    begin
      u_bus_host.ticks(1);
      n++;
    end
    n += 4 + eeprom_engine_pkg::STATUS_CYCLES + 5 + 4 + 160;
    check_flag(n >= PROG - 10 && n <= PROG + 40, 1'b1);
    u_bus_host.ticks(2);
    check_flag(u_bus_host.q_line, 1'b1);
    u_bus_host.frame_end();
    check_flag(dout_oe_n, 1'b1);
  endtask
  task automatic read_check(input logic [7:0] ra, input int n);
    u_bus_host.read_seq(ra, wide_addr, n, rw, dq);
    check_flag(dq, 1'b0);
    for (int k = 0; k < n; k++)
    begin
      check_word(rw[k], mem[8'(ra + k) & (wide_addr ? 8'hFF : 8'h3F)]);
    end
  endtask
  // ********
  // main sequence
  // ********
  initial
  begin
    rstn = 1'b0;
    write_permit = 1'b1;
    wide_addr = 1'b1;
    boundary_addr = 8'hBF;
    boundary_cleared = 1'b0;
    num_errors = 0;
    compares = 0;
    repeat (10) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    check_flag(write_enabled, 1'b0);
    check_flag(busy, 1'b0);
    check_flag(dout_oe_n, 1'b1);
    u_bus_host.ticks(4);
    r = rnd();
    a0 = {2'h0, r[5:0]};
    d = r[31:16];
    w = wr_bits(eeprom_engine_pkg::OP_WRITE, a0, d);
    instr(w, 27);
    check_flag(busy, 1'b0);
    end_test("locked write");
    instr(wr_bits(eeprom_engine_pkg::OP_EXT, {eeprom_engine_pkg::EXT_UNLOCK, 6'h00},
                  16'h0000) >> 16, 11);
    check_flag(write_enabled, 1'b1);
    instr(w >> 12, 15);
    check_flag(busy, 1'b0);
    instr({w[30:0], 1'b0}, 28);
    check_flag(busy, 1'b0);
    end_test("aborts");
    instr(w, 29);
    mem[a0] = d;
    prog_status();
    check_flag(write_enabled, 1'b1);
    end_test("word write");
    r = rnd();
    a = {2'h1, r[5:2], 2'h2};
    u_bus_host.frame_start();
    u_bus_host.send_bits(wr_bits(eeprom_engine_pkg::OP_PAGE, a, 16'h0000) >> 16, 11);
    for (int k = 0; k < 4; k++)
    begin
      d = 16'(rnd());
      mem[page_addr(a, k)] = d;
      u_bus_host.send_bits({16'h0000, d}, 16);
    end
    u_bus_host.frame_end();
    prog_status();
    read_check({a[7:2], 2'h0}, 4);
    read_check(a0, 1);
    instr(wr_bits(eeprom_engine_pkg::OP_PAGE, 8'hBC, 16'(rnd())), 27);
    check_flag(busy, 1'b0);
    end_test("page write");
    d = 16'(rnd());
    w = wr_bits(eeprom_engine_pkg::OP_EXT, {eeprom_engine_pkg::EXT_FILL, 6'h00}, d);
    instr(w, 27);
    check_flag(busy, 1'b0);
    boundary_cleared = 1'b1;
    u_bus_host.ticks(2);
    instr(w, 27);
    for (int i = 0; i < 256; i++)
    begin
      mem[i] = d;
    end
    prog_status();
    read_check(8'(rnd()), 4);
    end_test("fill");
    write_permit = 1'b0;
    u_bus_host.ticks(2);
    instr(wr_bits(eeprom_engine_pkg::OP_WRITE, a0, ~d), 27);
    check_flag(busy, 1'b0);
    write_permit = 1'b1;
    instr(wr_bits(eeprom_engine_pkg::OP_EXT, {eeprom_engine_pkg::EXT_LOCK, 6'h00},
                  16'h0000) >> 16, 11);
    check_flag(write_enabled, 1'b0);
    instr(wr_bits(eeprom_engine_pkg::OP_WRITE, a0, ~d), 27);
    check_flag(busy, 1'b0);
    read_check(a0, 1);
    wide_addr = 1'b0;
    u_bus_host.ticks(4);
    read_check(8'h3F, 2);
    end_test("lock and narrow read");
    report_and_stop();
  end
  // watchdog well beyond the expected run of about 6000 cycles
  initial
  begin
    #400000;
    num_errors++;
    report_and_stop();
  end
endmodule
